// File: tb_top.sv
// self-checking bench for the receive gain decoder and tone generator
`timescale 1ns/1ps
module tb_top;
  reg ref_clk, sys_rst, chip_enable;
  wire scl, sda_in, sda_out, sda_oe_n, pcm_clk, pcm_frame_sync, pcm_rx_data;
  wire st_mute, ep_mute, diff_en, se_en, rx_valid, rx_comp, buzz;
  wire [4:0] st_db, ep_db;
  wire [14:0] rx_word;
  integer miscompares, checks, nvalid, nbuzz, c;
  reg [14:0] last_word;
  reg [2:0] nk;
  reg [7:0] d;
  tgr_rx_tone dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .chip_enable(chip_enable), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pcm_clk(pcm_clk),
    .pcm_frame_sync(pcm_frame_sync), .pcm_rx_data(pcm_rx_data), .sidetone_atten_db(st_db),
    .sidetone_mute(st_mute), .earphone_atten_db(ep_db), .earphone_mute(ep_mute),
    .diff_earphone_en(diff_en), .single_ended_earphone_en(se_en), .rx_word(rx_word),
    .rx_word_valid(rx_valid), .rx_word_companded(rx_comp), .buzzer_control_output(buzz));
  tgr_bb_model bb (.ref_clk(ref_clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda_in(sda_in),
    .pcm_clk(pcm_clk), .pcm_frame_sync(pcm_frame_sync), .pcm_rx_data(pcm_rx_data));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (rx_valid)
      last_word <= rx_word;
    nvalid <= nvalid + rx_valid;
    nbuzz <= nbuzz + buzz;
  end
  // ----
  // checks
  // ----
  task chk(input [63:0] nm, input [15:0] exp, input [15:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task t_reset;
    begin
      chk("st_db", 16'h000c, st_db);
      chk("ep_db", 16'h0000, ep_db);
      chk("st_mute", 16'h0001, st_mute);
      chk("ep_mute", 16'h0000, ep_mute);
      chk("amp", 16'h0002, {diff_en, se_en});
      chk("buzz", 16'h0000, buzz);
      bb.rd(8'h00, d, nk);
      chk("reg00", 16'h00f6, d);
      bb.rd(8'h06, d, nk);
      chk("reg06", 16'h0000, d);
      bb.rd(8'h07, d, nk);
      chk("reg07", 16'h0000, d);
      $display("test reset done");
    end
  endtask
  task t_gain;
    begin
      for (c = 0; c < 8; c = c + 1) begin
        bb.wr(8'h02, 8'h40 | c[7:0], nk);
        chk("st_db", (c < 7) ? 12 + 2 * c : 24, st_db);
      end
      for (c = 0; c < 16; c = c + 1) begin
        bb.wr(8'h03, 8'ha0 | c[7:0], nk);
        chk("ep_db", (c < 10) ? 2 * c : 18, ep_db);
      end
      $display("test gain done");
    end
  endtask
  task t_power;
    begin
      bb.wr(8'h00, 8'h7c, nk);
      chk("st_mute", 16'h0000, st_mute);
      chk("ep_mute", 16'h0001, ep_mute);
      chk("amp", 16'h0001, {diff_en, se_en});
      chip_enable <= 1'b0;
      bb.wr(8'h02, 8'h43, nk);
      chk("nak", 16'h0007, nk);
      chk("st_db", 16'h0018, st_db);
      chip_enable <= 1'b1;
      bb.tick(4);
      $display("test power done");
    end
  endtask
  task t_pcm;
    begin
      bb.wr(8'h01, 8'h02, nk);
      c = nvalid;
      bb.frame({15'h2b4d, 1'b1});
      bb.tick(8);
      chk("nvalid", c + 1, nvalid);
      chk("lin", 16'h2b4d, last_word);
      chk("comp", 16'h0000, rx_comp);
      bb.wr(8'h01, 8'h12, nk);
      c = nvalid;
      bb.frame({8'ha7, 8'hff});
      bb.tick(8);
      chk("nvalid", c + 1, nvalid);
      chk("cmp", 16'h00a7, last_word);
      chk("comp", 16'h0001, rx_comp);
      $display("test pcm done");
    end
  endtask
  // peak over eight frames, so the sampling phase does not matter
  task tone(input [7:0] hi, input [7:0] lo, input [14:0] pk_exp);
    integer i, k;
    reg [14:0] pk;
    begin
      bb.wr(8'h04, hi, nk);
      bb.wr(8'h05, lo, nk);
      bb.rd(8'h04, d, nk);
      chk("reg04", {8'h00, hi}, d);
      pk = 15'h0000;
      for (i = 0; i < 8; i = i + 1) begin
        bb.sync_pulse;
        k = 0;
        while (rx_valid !== 1'b1 && k < 40) begin
          @(negedge ref_clk);
          k = k + 1;
        end
        chk("tvalid", 16'h0001, k < 40);
        if ($signed(rx_word) > $signed(pk))
          pk = rx_word;
        bb.tick(100);
      end
      chk("peak", {1'b0, pk_exp}, {1'b0, pk});
    end
  endtask
  task t_tone;
    begin
      bb.wr(8'h01, 8'h4a, nk);
      bb.wr(8'h03, 8'h60, nk);
      c = nbuzz;
      tone(8'h40, 8'h00, 15'h1380);
      tone(8'h00, 8'h40, 15'h0f80);
      tone(8'h40, 8'h40, 15'h2300);
      chk("buzz", 16'h0001, nbuzz > c);
      bb.wr(8'h06, 8'h28, nk);
      tone(8'h10, 8'h10, 15'h2300);
      bb.wr(8'h03, 8'h00, nk);
      tone(8'h40, 8'h40, 15'h3fff);
      $display("test tone done");
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    miscompares = 0;
    checks = 0;
    nvalid = 0;
    nbuzz = 0;
    last_word = 15'h0000;
    sys_rst = 1'b1;
    chip_enable = 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    bb.tick(4);
    t_reset;
    t_gain;
    t_power;
    t_pcm;
    t_tone;
    tally_and_finish;
  end
  initial begin
    #700000;
    miscompares = miscompares + 1;
    tally_and_finish;
  end
endmodule

// File: tgr_bb_model.sv
// baseband controller model: control bus master and receive frame source
`timescale 1ns/1ps
module tgr_bb_model (
  input wire ref_clk,
  input wire sda_oe_n,
  output reg scl,
  output wire sda_in,
  output reg pcm_clk,
  output reg pcm_frame_sync,
  output reg pcm_rx_data
);
  reg sda_m;
  // pull-up: line is low if either side pulls
  assign sda_in = sda_m & sda_oe_n;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    pcm_clk = 1'b0;
    pcm_frame_sync = 1'b0;
    pcm_rx_data = 1'b0;
  end
  // ----
  // control bus
  // ----
  task tick(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  task start_cond;
    begin
      sda_m <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(8);
      sda_m <= 1'b0;
      tick(8);
      scl <= 1'b0;
    end
  endtask
  task stop_cond;
    begin
      tick(4);
      sda_m <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(8);
      sda_m <= 1'b1;
      tick(8);
    end
  endtask
  task bit_io(input b, output r);
    begin
      tick(4);
      sda_m <= b;
      tick(4);
      scl <= 1'b1;
      tick(4);
      r = sda_in;
      tick(4);
      scl <= 1'b0;
    end
  endtask
  task xfer(input [7:0] tx, output [7:0] rx, output nak);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(tx[i], r);
        rx[i] = r;
      end
      bit_io(1'b1, nak);
    end
  endtask
  task wr(input [7:0] p, input [7:0] dt, output [2:0] nk);
    reg [7:0] x;
    begin
      start_cond;
      xfer(8'he2, x, nk[2]);
      xfer(p, x, nk[1]);
      xfer(dt, x, nk[0]);
      stop_cond;
    end
  endtask
  // a nack on the last byte ends the read
  task rd(input [7:0] p, output [7:0] dt, output [2:0] nk);
    reg [7:0] x;
    begin
      start_cond;
      xfer(8'he2, x, nk[2]);
      xfer(p, x, nk[1]);
      start_cond;
      xfer(8'he3, x, nk[0]);
      xfer(8'hff, dt, x[0]);
      stop_cond;
    end
  endtask
  // ----
  // receive link
  // ----
  // msb first, bits past the word are junk; clock stands still between frames
  task frame(input [15:0] bits);
    integer i;
    begin
      for (i = 15; i >= 0; i = i - 1) begin
        pcm_frame_sync <= (i == 15);
        pcm_rx_data <= bits[i];
        pcm_clk <= 1'b1;
        tick(4);
        pcm_clk <= 1'b0;
        tick(4);
      end
      pcm_frame_sync <= 1'b0;
      pcm_rx_data <= ~bits[0];
    end
  endtask
  // frames come closer than 8 kHz here to keep the run short
  task sync_pulse;
    begin
      pcm_frame_sync <= 1'b1;
      tick(4);
      pcm_frame_sync <= 1'b0;
    end
  endtask
endmodule

// File: tgr_defs.vh
// constants shared by the receive-gain decoder and tone generator
`ifndef TGR_DEFS_VH
`define TGR_DEFS_VH
// How it works
// - sidetone code 0..6 gives 12..24 dB attenuation
// - power control bit 7 mutes sidetone
// - reset sidetone setting is 12 dB
// - volume code 0..9 gives 0..18 dB attenuation
// - reset volume setting is 0 dB
// - exactly one earphone amplifier is selected
// - power control bit 3 mutes earphone
// - companded sample is 8 bits, MSB first
// - linear sample is 15 bits, MSB first
// - trailing frame bits after data are ignored
// - tone words live at registers 04 and 05
// - high tone is 2 dB louder
// - aux bits 2..5 pick tone resolution
// - finest resolution reaches 1992.2 Hz, coarser wider
// - tone mode scales tone by receive gain
// - tones reach all outputs, gated by enables
// - word write starts table look-up
// - low tone peak 31 becomes 3968
// - high tone peak 39 becomes 4992
// - summed peak 70 becomes 8960
// - selected tone drives buzzer density stream
// - master clock drives all internal timing
// - control slave active only with chip enable

// ----------------------------------------
// control interface
// ----------------------------------------
`define TGR_I2C_DEV_ADDR 7'h71
`define TGR_REG_PWR 3'h0
`define TGR_REG_MODE 3'h1
`define TGR_REG_TXG 3'h2
`define TGR_REG_RXG 3'h3
`define TGR_REG_HI 3'h4
`define TGR_REG_LO 3'h5
`define TGR_REG_AUX 3'h6
`define TGR_RST_PWR 8'hF6
`define TGR_RST_MODE 8'h02
`define TGR_RST_TXG 8'h40
`define TGR_RST_RXG 8'hA0
`define TGR_RST_ZERO 8'h00
`define TGR_BYTE_BITS 4'h8

// ----------------------------------------
// field positions
// ----------------------------------------
`define TGR_PWR_ST_MUTE 7
`define TGR_PWR_EAR_MUTE 3
`define TGR_PWR_EAR_SEL 1
`define TGR_MODE_TONE 6
`define TGR_MODE_COMP 4
`define TGR_MODE_BUZZ 3
`define TGR_ST_FIELD 2:0
`define TGR_RV_FIELD 3:0
`define TGR_RP_FIELD 7:4
`define TGR_AUX_HI_RES 5:4
`define TGR_AUX_LO_RES 3:2

// ----------------------------------------
// gain decoding
// ----------------------------------------
`define TGR_ST_MAX_CODE 3'h6
`define TGR_ST_BASE_DB 5'h0C
`define TGR_ST_WORST_DB 5'h18
`define TGR_RV_MAX_CODE 4'h9
`define TGR_RV_WORST_DB 5'h12
`define TGR_RP_P12_MAX 4'h2
`define TGR_RP_P6_MAX 4'h5
`define TGR_RP_0_MAX 4'h8
`define TGR_RP_M6_MAX 4'hB
`define TGR_SH_P12 5'h09
`define TGR_SH_P6 5'h08
`define TGR_SH_0 5'h07
`define TGR_SH_M6 5'h06
`define TGR_SH_M12 5'h05

// ----------------------------------------
// sample words
// ----------------------------------------
`define TGR_COMP_BITS 4'h8
`define TGR_LIN_BITS 4'hF
`define TGR_SAT_POS 18'h0_3FFF
`define TGR_SAT_NEG 18'h3_C000
`define TGR_QUARTER 5'h10
`endif

// File: tgr_rx_tone.v
// receive gain decoder, pcm receiver, tone generator and buzzer
`timescale 1ns/1ps
`include "tgr_defs.vh"
module tgr_rx_tone #(
  parameter PH_W = 10
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire chip_enable,
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  input wire pcm_clk,
  input wire pcm_frame_sync,
  input wire pcm_rx_data,
  output reg [4:0] sidetone_atten_db,
  output reg sidetone_mute,
  output reg [4:0] earphone_atten_db,
  output reg earphone_mute,
  output reg diff_earphone_en,
  output reg single_ended_earphone_en,
  output reg [14:0] rx_word,
  output reg rx_word_valid,
  output reg rx_word_companded,
  output reg buzzer_control_output
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [4:0] I_IDLE = 5'b00001;
  localparam [4:0] I_DEV = 5'b00010;
  localparam [4:0] I_PTR = 5'b00100;
  localparam [4:0] I_WR = 5'b01000;
  localparam [4:0] I_RD = 5'b10000;
  localparam [3:0] F_IDLE = 4'b0001;
  localparam [3:0] F_HI = 4'b0010;
  localparam [3:0] F_LO = 4'b0100;
  localparam [3:0] F_SUM = 4'b1000;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [PH_W-1:0] tone_inc;
    input [7:0] word;
    input [1:0] res;
    begin
      // 255 steps of 7.8125 Hz top out at 1992.2 Hz; coarser settings double or quadruple
      if (res == 2'b00) begin
        tone_inc = {{(PH_W-8){1'b0}}, word};
      end else if (res == 2'b01) begin
        tone_inc = {{(PH_W-8){1'b0}}, word} << 1;
      end else begin
        tone_inc = {{(PH_W-8){1'b0}}, word} << 2;
      end
    end
  endfunction

  function [4:0] quarter_index;
    input [PH_W-1:0] ph;
    begin
      if (ph[PH_W-2]) begin
        quarter_index = `TGR_QUARTER - {1'b0, ph[PH_W-3:PH_W-6]};
      end else begin
        quarter_index = {1'b0, ph[PH_W-3:PH_W-6]};
      end
    end
  endfunction

  function [8:0] signed_tone;
    input [7:0] mag;
    input neg;
    input [7:0] word;
    begin
      if (word == `TGR_RST_ZERO) begin
        signed_tone = 9'h000;
      end else if (neg) begin
        signed_tone = 9'h000 - {1'b0, mag};
      end else begin
        signed_tone = {1'b0, mag};
      end
    end
  endfunction

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg [5:0] sync1;
  reg [5:0] sync2;
  reg [5:0] sync3;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= 6'h3F;
      sync2 <= 6'h3F;
      sync3 <= 6'h3F;
    end else begin
      sync1 <= {chip_enable, scl, sda_in, pcm_clk, pcm_frame_sync, pcm_rx_data};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  wire ce_s = sync2[5];
  wire scl_s = sync2[4];
  wire sda_s = sync2[3];
  wire scl_rise = sync2[4] & ~sync3[4];
  wire scl_fall = ~sync2[4] & sync3[4];
  wire i2c_start = sync2[4] & sync3[4] & ~sync2[3] & sync3[3];
  wire i2c_stop = sync2[4] & sync3[4] & sync2[3] & ~sync3[3];
  wire pclk_fall = ~sync2[2] & sync3[2];
  wire fsync_s = sync2[1];
  wire frame_tick = sync2[1] & ~sync3[1];
  wire pdata_s = sync2[0];

  // ----------------------------------------
  // registers and control slave
  // ----------------------------------------
  reg [7:0] pwr_ctrl;
  reg [7:0] mode_ctrl;
  reg [7:0] tx_gain;
  reg [7:0] receive_gain_field;
  reg [7:0] high_tone_frequency_word;
  reg [7:0] low_tone_frequency_word;
  reg [7:0] aux_ctrl;
  reg [4:0] i_state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] rdbuf;
  reg [2:0] ptr;
  reg ack_ph;
  reg tone_restart;
  reg [7:0] rd_val;

  always @* begin
    if (ptr == `TGR_REG_PWR) begin
      rd_val = pwr_ctrl;
    end else if (ptr == `TGR_REG_MODE) begin
      rd_val = mode_ctrl;
    end else if (ptr == `TGR_REG_TXG) begin
      rd_val = tx_gain;
    end else if (ptr == `TGR_REG_RXG) begin
      rd_val = receive_gain_field;
    end else if (ptr == `TGR_REG_HI) begin
      rd_val = high_tone_frequency_word;
    end else if (ptr == `TGR_REG_LO) begin
      rd_val = low_tone_frequency_word;
    end else if (ptr == `TGR_REG_AUX) begin
      rd_val = aux_ctrl;
    end else begin
      rd_val = `TGR_RST_ZERO;
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_ctrl <= `TGR_RST_PWR;
      mode_ctrl <= `TGR_RST_MODE;
      tx_gain <= `TGR_RST_TXG;
      receive_gain_field <= `TGR_RST_RXG;
      high_tone_frequency_word <= `TGR_RST_ZERO;
      low_tone_frequency_word <= `TGR_RST_ZERO;
      aux_ctrl <= `TGR_RST_ZERO;
      i_state <= I_IDLE;
      bit_cnt <= 4'h0;
      shreg <= `TGR_RST_ZERO;
      rdbuf <= `TGR_RST_ZERO;
      ptr <= 3'h0;
      ack_ph <= 1'b0;
      tone_restart <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      tone_restart <= 1'b0;
      if (!ce_s || i2c_stop) begin
        i_state <= I_IDLE;
        sda_oe_n <= 1'b1;
        ack_ph <= 1'b0;
      end else if (i2c_start) begin
        i_state <= I_DEV;
        bit_cnt <= 4'h0;
        ack_ph <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        if (ack_ph) begin
          // a master nack ends a read burst
          if ((i_state == I_RD) && sda_s) begin
            i_state <= I_IDLE;
            ack_ph <= 1'b0;
          end
        end else if (i_state != I_IDLE) begin
          shreg <= {shreg[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end
      end else if (scl_fall && !scl_s) begin
        if (ack_ph) begin
          ack_ph <= 1'b0;
          sda_oe_n <= 1'b1;
          if (i_state == I_RD) begin
            sda_oe_n <= rd_val[7];
            rdbuf <= {rd_val[6:0], 1'b0};
            ptr <= ptr + 3'h1;
          end
        end else if (bit_cnt == `TGR_BYTE_BITS) begin
          bit_cnt <= 4'h0;
          case (i_state)
            I_DEV: begin
              if (shreg[7:1] == `TGR_I2C_DEV_ADDR) begin
                ack_ph <= 1'b1;
                sda_oe_n <= 1'b0;
                i_state <= shreg[0] ? I_RD : I_PTR;
              end else begin
                i_state <= I_IDLE;
              end
            end
            I_PTR: begin
              ptr <= shreg[2:0];
              ack_ph <= 1'b1;
              sda_oe_n <= 1'b0;
              i_state <= I_WR;
            end
            I_WR: begin
              ack_ph <= 1'b1;
              sda_oe_n <= 1'b0;
              ptr <= ptr + 3'h1;
              if (ptr == `TGR_REG_PWR) begin
                pwr_ctrl <= shreg;
              end else if (ptr == `TGR_REG_MODE) begin
                mode_ctrl <= shreg;
              end else if (ptr == `TGR_REG_TXG) begin
                tx_gain <= shreg;
              end else if (ptr == `TGR_REG_RXG) begin
                receive_gain_field <= shreg;
              end else if (ptr == `TGR_REG_HI) begin
                high_tone_frequency_word <= shreg;
                tone_restart <= 1'b1;
              end else if (ptr == `TGR_REG_LO) begin
                low_tone_frequency_word <= shreg;
                tone_restart <= 1'b1;
              end else if (ptr == `TGR_REG_AUX) begin
                aux_ctrl <= shreg;
              end
            end
            I_RD: begin
              ack_ph <= 1'b1;
              sda_oe_n <= 1'b1;
            end
            default: begin
              i_state <= I_IDLE;
            end
          endcase
        end else if (i_state == I_RD) begin
          sda_oe_n <= rdbuf[7];
          rdbuf <= {rdbuf[6:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------
  // gain decoding and output routing
  // ----------------------------------------
  wire [2:0] st_code = tx_gain[`TGR_ST_FIELD];
  wire [3:0] rv_code = receive_gain_field[`TGR_RV_FIELD];
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sidetone_atten_db <= `TGR_ST_BASE_DB;
      sidetone_mute <= 1'b1;
      earphone_atten_db <= 5'h00;
      earphone_mute <= 1'b0;
      diff_earphone_en <= 1'b1;
      single_ended_earphone_en <= 1'b0;
    end else begin
      if (st_code > `TGR_ST_MAX_CODE) begin
        sidetone_atten_db <= `TGR_ST_WORST_DB;
      end else begin
        sidetone_atten_db <= `TGR_ST_BASE_DB + {1'b0, st_code, 1'b0};
      end
      if (rv_code > `TGR_RV_MAX_CODE) begin
        earphone_atten_db <= `TGR_RV_WORST_DB;
      end else begin
        earphone_atten_db <= {rv_code, 1'b0};
      end
      sidetone_mute <= pwr_ctrl[`TGR_PWR_ST_MUTE];
      earphone_mute <= pwr_ctrl[`TGR_PWR_EAR_MUTE];
      // enables depend on the select bit only, in voice and tone mode alike
      diff_earphone_en <= pwr_ctrl[`TGR_PWR_EAR_SEL];
      single_ended_earphone_en <= ~pwr_ctrl[`TGR_PWR_EAR_SEL];
    end
  end

  // ----------------------------------------
  // pcm receive shifter
  // ----------------------------------------
  wire comp_mode = mode_ctrl[`TGR_MODE_COMP];
  wire tone_mode = mode_ctrl[`TGR_MODE_TONE];
  reg [14:0] pcm_sh;
  reg [3:0] pcm_cnt;
  reg pcm_busy;
  reg pcm_done;
  wire [3:0] pcm_len = comp_mode ? `TGR_COMP_BITS : `TGR_LIN_BITS;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pcm_sh <= 15'h0000;
      pcm_cnt <= 4'h0;
      pcm_busy <= 1'b0;
      pcm_done <= 1'b0;
    end else begin
      pcm_done <= 1'b0;
      if (pclk_fall) begin
        if (fsync_s && !pcm_busy) begin
          pcm_sh <= {14'h0000, pdata_s};
          pcm_cnt <= 4'h1;
          pcm_busy <= 1'b1;
        end else if (pcm_busy) begin
          pcm_sh <= {pcm_sh[13:0], pdata_s};
          pcm_cnt <= pcm_cnt + 4'h1;
          // bits after the data word are never shifted in
          if (pcm_cnt + 4'h1 == pcm_len) begin
            pcm_busy <= 1'b0;
            pcm_done <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // tone generator
  // ----------------------------------------
  reg [PH_W-1:0] phase_hi;
  reg [PH_W-1:0] phase_lo;
  reg [3:0] f_state;
  reg [8:0] hi_sample;
  reg [8:0] tone_sum;
  reg tone_done;
  wire [15:0] rom_data;
  wire [4:0] rom_addr = (f_state == F_HI) ? quarter_index(phase_hi) : quarter_index(phase_lo);
  wire [8:0] lo_sample = signed_tone(rom_data[7:0], phase_lo[PH_W-1], low_tone_frequency_word);

  tgr_tone_rom u_rom (
    .ref_clk(ref_clk),
    .addr(rom_addr),
    .data(rom_data)
  );

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_hi <= {PH_W{1'b0}};
      phase_lo <= {PH_W{1'b0}};
      f_state <= F_IDLE;
      hi_sample <= 9'h000;
      tone_sum <= 9'h000;
      tone_done <= 1'b0;
    end else begin
      tone_done <= 1'b0;
      if (tone_restart) begin
        phase_hi <= {PH_W{1'b0}};
        phase_lo <= {PH_W{1'b0}};
      end else if (frame_tick && tone_mode) begin
        phase_hi <= phase_hi + tone_inc(high_tone_frequency_word, aux_ctrl[`TGR_AUX_HI_RES]);
        phase_lo <= phase_lo + tone_inc(low_tone_frequency_word, aux_ctrl[`TGR_AUX_LO_RES]);
      end
      case (f_state)
        F_IDLE: begin
          if (tone_restart || (frame_tick && tone_mode)) begin
            f_state <= F_HI;
          end
        end
        F_HI: begin
          f_state <= F_LO;
        end
        F_LO: begin
          // table entries for the high tone are the larger set
          hi_sample <= signed_tone(rom_data[15:8], phase_hi[PH_W-1], high_tone_frequency_word);
          f_state <= F_SUM;
        end
        F_SUM: begin
          tone_sum <= hi_sample + lo_sample;
          tone_done <= 1'b1;
          f_state <= F_IDLE;
        end
        default: begin
          f_state <= F_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // tone scaling and receive word
  // ----------------------------------------
  wire [3:0] rp_code = receive_gain_field[`TGR_RP_FIELD];
  reg [4:0] tone_sh;
  reg [17:0] tone_scaled;
  reg [14:0] tone_word;
  wire [17:0] sat_pos = `TGR_SAT_POS;
  wire [17:0] sat_neg = `TGR_SAT_NEG;
  always @* begin
    // seven places is unity; tone-mode gain adds or removes places
    if (rp_code <= `TGR_RP_P12_MAX) begin
      tone_sh = `TGR_SH_P12;
    end else if (rp_code <= `TGR_RP_P6_MAX) begin
      tone_sh = `TGR_SH_P6;
    end else if (rp_code <= `TGR_RP_0_MAX) begin
      tone_sh = `TGR_SH_0;
    end else if (rp_code <= `TGR_RP_M6_MAX) begin
      tone_sh = `TGR_SH_M6;
    end else begin
      tone_sh = `TGR_SH_M12;
    end
    tone_scaled = {{9{tone_sum[8]}}, tone_sum} << tone_sh;
    // +12 dB on a full dual tone would wrap, so clip to full scale
    if (!tone_scaled[17] && (tone_scaled > sat_pos)) begin
      tone_word = sat_pos[14:0];
    end else if (tone_scaled[17] && (tone_scaled <= sat_neg)) begin
      tone_word = 15'h0000 - sat_pos[14:0];
    end else begin
      tone_word = tone_scaled[14:0];
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_word <= 15'h0000;
      rx_word_valid <= 1'b0;
      rx_word_companded <= 1'b0;
    end else begin
      rx_word_valid <= 1'b0;
      if (tone_mode && tone_done) begin
        rx_word <= tone_word;
        rx_word_valid <= 1'b1;
        rx_word_companded <= 1'b0;
      end else if (!tone_mode && pcm_done) begin
        rx_word <= comp_mode ? {7'h00, pcm_sh[7:0]} : pcm_sh;
        rx_word_valid <= 1'b1;
        rx_word_companded <= comp_mode;
      end
    end
  end

  // ----------------------------------------
  // buzzer density modulator
  // ----------------------------------------
  // first-order loop on the master clock; one bit per cycle
  reg [14:0] pdm_acc;
  wire [15:0] pdm_sum = {1'b0, pdm_acc} + {1'b0, ~rx_word[14], rx_word[13:0]};
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pdm_acc <= 15'h0000;
      buzzer_control_output <= 1'b0;
    end else begin
      pdm_acc <= pdm_sum[14:0];
      buzzer_control_output <= mode_ctrl[`TGR_MODE_BUZZ] & tone_mode & pdm_sum[15];
    end
  end
endmodule

// File: tgr_rx_tone_props.sv
// port checker for the receive gain decoder and tone generator
`timescale 1ns/1ps
module tgr_rx_tone_props (
  input wire ref_clk,
  input wire sys_rst,
  input wire chip_enable,
  input wire sda_out,
  input wire sda_oe_n,
  input wire [4:0] sidetone_atten_db,
  input wire [4:0] earphone_atten_db,
  input wire diff_earphone_en,
  input wire single_ended_earphone_en,
  input wire [14:0] rx_word,
  input wire rx_word_valid,
  input wire rx_word_companded
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_st_grid: assert property (sidetone_atten_db >= 5'h0c && sidetone_atten_db <= 5'h18 && !sidetone_atten_db[0])
    else $error("sidetone attenuation off its grid");
  a_ep_grid: assert property (earphone_atten_db <= 5'h12 && !earphone_atten_db[0])
    else $error("earphone attenuation off its grid");
  a_reset_gains: assert property ($fell(sys_rst) |-> sidetone_atten_db == 5'h0c && earphone_atten_db == 5'h00)
    else $error("gains not at reset setting");
  a_amp_onehot: assert property (diff_earphone_en != single_ended_earphone_en)
    else $error("earphone amplifier selection not exclusive");
  a_comp_upper: assert property (rx_word_valid && rx_word_companded |-> rx_word[14:8] == 7'h00)
    else $error("companded word has upper bits set");
  a_word_hold: assert property ($changed(rx_word) |-> rx_word_valid)
    else $error("receive word changed without valid");
  a_valid_gap: assert property (rx_word_valid |=> !rx_word_valid [*8])
    else $error("receive words too close together");
  a_word_sat: assert property (rx_word_valid |-> rx_word != 15'h4000)
    else $error("receive word beyond saturation limit");
  a_ce_idle: assert property (!chip_enable [*6] |-> sda_oe_n)
    else $error("data line driven while disabled");
  a_gain_cause: assert property ($changed(sidetone_atten_db) |-> $past(chip_enable))
    else $error("gain changed while control slave disabled");
  a_sda_zero: assert property (!sda_oe_n |-> !sda_out)
    else $error("data line driven high");
  c_comp: cover property (rx_word_valid && rx_word_companded);
  c_lin: cover property (rx_word_valid && !rx_word_companded);
  c_ack: cover property ($fell(sda_oe_n));
endmodule

bind tgr_rx_tone tgr_rx_tone_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst), .chip_enable(chip_enable),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sidetone_atten_db(sidetone_atten_db),
  .earphone_atten_db(earphone_atten_db), .diff_earphone_en(diff_earphone_en),
  .single_ended_earphone_en(single_ended_earphone_en), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
  .rx_word_companded(rx_word_companded));

// File: tgr_tone_rom.v
// quarter-wave table for both tone amplitudes
`timescale 1ns/1ps
module tgr_tone_rom (
  input wire ref_clk,
  input wire [4:0] addr,
  output reg [15:0] data
);
  // ----------------------------------------
  // {high-tone magnitude, low-tone magnitude}
  // ----------------------------------------
  // high entries peak at 39 and low at 31, about 2 dB apart
  always @(posedge ref_clk) begin
    case (addr)
      5'h00: data <= 16'h0000;
      5'h01: data <= 16'h0403;
      5'h02: data <= 16'h0806;
      5'h03: data <= 16'h0B09;
      5'h04: data <= 16'h0F0C;
      5'h05: data <= 16'h120F;
      5'h06: data <= 16'h1611;
      5'h07: data <= 16'h1914;
      5'h08: data <= 16'h1C16;
      5'h09: data <= 16'h1E18;
      5'h0A: data <= 16'h201A;
      5'h0B: data <= 16'h221B;
      5'h0C: data <= 16'h241D;
      5'h0D: data <= 16'h251E;
      5'h0E: data <= 16'h261E;
      5'h0F: data <= 16'h271F;
      5'h10: data <= 16'h271F;
      default: data <= 16'h0000;
    endcase
  end
endmodule
